/* inc/rca_link_if.sv */
// link between the aligner device and its configuring user logic
`timescale 1ns/10ps
interface rca_link_if;
    logic                           comma_logic_enable;
    logic                           plus_align_enable;
    logic                           minus_align_enable;
    logic                           bit_slip_request;
    logic                           paired_mode;
    logic                           plus_detect_report;
    logic                           minus_detect_report;
    logic [1:0]                     gran_code;
    logic                           internal_width;
    rca_pkg::rca_slip_t             slip_mode_select;
    logic [rca_pkg::SYM_W-1:0]      plus_comma_pattern;
    logic [rca_pkg::SYM_W-1:0]      minus_comma_pattern;
    logic [rca_pkg::SYM_W-1:0]      comma_mask;
    logic [rca_pkg::WORD_W-1:0]     parallel_rx_word;
    logic                           byte_aligned_flag;
    logic                           realign_pulse;
    logic                           comma_seen;
    logic                           recovered_phase_step;

    modport dev (
        input  comma_logic_enable, plus_align_enable, minus_align_enable,
        input  bit_slip_request, paired_mode, plus_detect_report, minus_detect_report,
        input  gran_code, internal_width, slip_mode_select,
        input  plus_comma_pattern, minus_comma_pattern, comma_mask,
        output parallel_rx_word, byte_aligned_flag, realign_pulse, comma_seen,
        output recovered_phase_step
    );

    modport host (
        output comma_logic_enable, plus_align_enable, minus_align_enable,
        output bit_slip_request, paired_mode, plus_detect_report, minus_detect_report,
        output gran_code, internal_width, slip_mode_select,
        output plus_comma_pattern, minus_comma_pattern, comma_mask,
        input  parallel_rx_word, byte_aligned_flag, realign_pulse, comma_seen,
        input  recovered_phase_step
    );
endinterface : rca_link_if

/* inc/rca_pkg.sv */
// constants, types and shared functions of the receive comma byte aligner
package rca_pkg;
    localparam int SYM_W   = 10;
    localparam int BYTES   = 4;
    localparam int WORD_W  = 40;
    localparam int WIN_W   = 80;
    localparam int POS_W   = 6;
    localparam int PIPE_N  = 3;

    // slip request timing in parallel clock cycles
    localparam logic [5:0] SLIP_HIGH_CYC = 6'h02;
    localparam logic [5:0] SLIP_LOW_MIN  = 6'h21;

    // boundary granularity codes
    localparam logic [1:0] GRAN_1 = 2'h0;
    localparam logic [1:0] GRAN_2 = 2'h1;
    localparam logic [1:0] GRAN_4 = 2'h2;
    localparam logic [5:0] SPAN_1 = 6'h0a;
    localparam logic [5:0] SPAN_2 = 6'h14;
    localparam logic [5:0] SPAN_4 = 6'h28;

    typedef enum logic [1:0] {
        RCA_SLIP_OFF   = 2'h0,
        RCA_SLIP_SHIFT = 2'h1,
        RCA_SLIP_DESER = 2'h3
    } rca_slip_t;

    // controller register map
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_PATTERN = 8'h04;
    localparam logic [7:0] OFS_MASK    = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0c;
    localparam logic [7:0] OFS_SLIP    = 8'h10;
    localparam logic [7:0] OFS_WORD_LO = 8'h14;
    localparam logic [7:0] OFS_WORD_HI = 8'h18;

    // control register fields
    localparam int CB_LOGIC_EN   = 0;
    localparam int CB_PLUS_AL    = 1;
    localparam int CB_MINUS_AL   = 2;
    localparam int CB_PAIRED     = 3;
    localparam int CB_PLUS_REP   = 4;
    localparam int CB_MINUS_REP  = 5;
    localparam int CB_GRAN_LO    = 6;
    localparam int CB_INT_WIDTH  = 8;
    localparam int CB_SLIP_LO    = 9;
    localparam int CB_ANY_POS    = 11;
    localparam int CTRL_W        = 12;
    localparam int PB_MINUS_LO   = 16;

    // status register fields
    localparam int SB_ALIGNED = 0;
    localparam int SB_REALIGN = 1;
    localparam int SB_COMMA   = 2;
    localparam int SB_BUSY    = 3;

    localparam logic [11:0] CTRL_RST  = 12'h177;
    localparam logic [9:0]  PLUS_RST  = 10'h17c;
    localparam logic [9:0]  MINUS_RST = 10'h283;
    localparam logic [9:0]  MASK_RST  = 10'h3ff;

    function automatic logic comma_match(input logic [SYM_W-1:0] data,
                                         input logic [SYM_W-1:0] pat,
                                         input logic [SYM_W-1:0] mask);
        comma_match = ((data ^ pat) & mask) == '0;
    endfunction : comma_match

    function automatic logic [POS_W-1:0] eff_span(input logic [1:0] gran,
                                                  input logic int_width);
        unique case (gran)
            GRAN_1:  eff_span = SPAN_1;
            GRAN_4:  eff_span = int_width ? SPAN_4 : SPAN_2;
            default: eff_span = SPAN_2;
        endcase
    endfunction : eff_span
endpackage : rca_pkg

/* src/rca_aligner_dev.sv */
// receive comma detector, byte aligner and manual bit slip
`timescale 1ns/10ps
// Summary of operation
// - landing positions from granularity, width, byte count
// - granularity 1 lands comma on any byte
// - granularity 2 lands comma on even bytes
// - granularity 4 needs 4-byte internal path
// - commas at any position need granularity 1
// - zero mask bits are don't-care in matching
// - paired mode needs plus then minus comma
// - paired mode needs equal reports and enables
// - comma logic enable low bypasses the aligner
// - align enable lets its polarity realign
// - aligned flag leads aligned data by cycles
// - flag set only by enabled comma polarities, cleared by any
// - realign flag marks a boundary change
// - comma seen leads comma on output
// - slip request high two, low over 32
// - one qualified slip moves exactly one bit
// - slip request overrides automatic alignment
// - manual slip: enables off, logic on
// - shift slip wraps after boundary span
// - deserializer slip shifts right, phase steps on every second one
// - off-boundary comma clears flag; an enabled one pulses realign
// - comma patterns are ten bits, bit 0 first
module rca_aligner_dev (
    input  wire logic                       sys_clk,     // parallel clock
    input  wire logic                       rst_n,       // async reset
    input  wire logic [rca_pkg::WORD_W-1:0] raw_word_in, // deserialized bits, bit 0 first
    rca_link_if.dev                         link         // configuration and status
);
    logic [rca_pkg::WORD_W-1:0] prev_reg;
    logic [rca_pkg::WIN_W-1:0]  window;
    logic [rca_pkg::POS_W-1:0]  span;
    logic [rca_pkg::POS_W-1:0]  shift_reg;
    logic [rca_pkg::POS_W-1:0]  tshift_reg;
    logic                       transient_reg;
    logic [rca_pkg::POS_W-1:0]  sel_shift;
    logic [rca_pkg::POS_W-1:0]  hit_pos;
    logic [rca_pkg::POS_W-1:0]  land_pos;
    logic                       plus_hit;
    logic                       minus_hit;
    logic                       enabled_hit;
    logic                       on_boundary;
    logic [rca_pkg::WORD_W-1:0] aligned_word;
    logic [rca_pkg::WORD_W-1:0] pipe_reg [rca_pkg::PIPE_N];
    logic [rca_pkg::WORD_W-1:0] word_reg;
    logic                       aligned_reg;
    logic                       realign_reg;
    logic                       seen_reg;
    logic                       req_d_reg;
    logic [5:0]                 low_cnt_reg;
    logic                       slip_take;
    logic                       parity_reg;
    logic                       phase_step_reg;

    function automatic logic [rca_pkg::POS_W-1:0] wrap_inc(input logic [rca_pkg::POS_W-1:0] v,
                                                          input logic [rca_pkg::POS_W-1:0] s);
        wrap_inc = (v + 6'h01 >= s) ? 6'h00 : v + 6'h01;
    endfunction : wrap_inc

    function automatic logic [rca_pkg::POS_W-1:0] wrap_dec(input logic [rca_pkg::POS_W-1:0] v,
                                                          input logic [rca_pkg::POS_W-1:0] s);
        wrap_dec = (v == 6'h00 || v >= s) ? s - 6'h01 : v - 6'h01;
    endfunction : wrap_dec

    // the older word sits in the low half, so bit 0 is the earliest bit seen
    assign window = {raw_word_in, prev_reg};

    // an invalid granularity 4 on the 2-byte path degrades to even lanes
    assign span = rca_pkg::eff_span(link.gran_code, link.internal_width);

    // earliest matching offset wins; paired mode needs both halves back to back
    always_comb begin
        logic pm;
        logic mm;
        pm        = 1'b0;
        mm        = 1'b0;
        plus_hit  = 1'b0;
        minus_hit = 1'b0;
        hit_pos   = '0;
        for (int p = 0; p < rca_pkg::WORD_W; p++) begin
            pm = rca_pkg::comma_match(window[p +: 10], link.plus_comma_pattern,
                                      link.comma_mask);
            mm = rca_pkg::comma_match(window[p +: 10], link.minus_comma_pattern,
                                      link.comma_mask);
            if (link.paired_mode) begin
                pm = pm && rca_pkg::comma_match(window[p+10 +: 10],
                                                link.minus_comma_pattern,
                                                link.comma_mask);
                mm = pm;
            end
            if (!plus_hit && !minus_hit && (pm || mm)) begin
                hit_pos   = 6'(p);
                plus_hit  = pm;
                minus_hit = mm;
            end
        end
    end

    // shift that puts the found comma on the nearest permitted lane
    always_comb begin
        land_pos = hit_pos;
        for (int k = 0; k < 3; k++) begin
            if (land_pos >= span) begin
                land_pos = land_pos - span;
            end
        end
    end

    assign enabled_hit = (plus_hit && link.plus_align_enable)
                       || (minus_hit && link.minus_align_enable);
    assign on_boundary = (land_pos == shift_reg);
    assign sel_shift   = transient_reg ? tshift_reg : shift_reg;
    assign aligned_word = window[sel_shift +: rca_pkg::WORD_W];

    // a new slip needs a rising edge after more than 32 low cycles
    assign slip_take = link.bit_slip_request && !req_d_reg
                     && (low_cnt_reg >= rca_pkg::SLIP_LOW_MIN)
                     && link.comma_logic_enable
                     && (link.slip_mode_select != rca_pkg::RCA_SLIP_OFF);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= raw_word_in;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_d_reg   <= 1'b0;
            low_cnt_reg <= rca_pkg::SLIP_LOW_MIN;
        end else begin
            req_d_reg <= link.bit_slip_request;
            if (link.bit_slip_request) begin
                low_cnt_reg <= 6'h00;
            end else if (low_cnt_reg < rca_pkg::SLIP_LOW_MIN) begin
                low_cnt_reg <= low_cnt_reg + 6'h01;
            end
        end
    end

    // boundary, flags and slips; a held slip request freezes auto alignment
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg     <= '0;
            tshift_reg    <= '0;
            transient_reg <= 1'b0;
            aligned_reg   <= 1'b0;
            realign_reg   <= 1'b0;
        end else begin
            realign_reg   <= 1'b0;
            transient_reg <= 1'b0;
            if (!link.comma_logic_enable) begin
                aligned_reg <= 1'b0;
            end else if (slip_take) begin
                if (link.slip_mode_select == rca_pkg::RCA_SLIP_SHIFT) begin
                    shift_reg <= wrap_inc(shift_reg, span);
                end else begin
                    // right shift by one, with one left-shifted word first
                    shift_reg     <= wrap_dec(shift_reg, span);
                    tshift_reg    <= wrap_inc(shift_reg, span);
                    transient_reg <= 1'b1;
                end
            end else if (!link.bit_slip_request && (plus_hit || minus_hit)) begin
                if (on_boundary) begin
                    if (enabled_hit) begin
                        aligned_reg <= 1'b1;
                    end
                end else begin
                    aligned_reg <= 1'b0;
                    if (enabled_hit) begin
                        shift_reg   <= land_pos;
                        realign_reg <= 1'b1;
                    end
                end
            end
        end
    end

    // recovered clock moves 2 UI on every second deserializer slip
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            parity_reg     <= 1'b0;
            phase_step_reg <= 1'b0;
        end else begin
            phase_step_reg <= 1'b0;
            if (slip_take && link.slip_mode_select == rca_pkg::RCA_SLIP_DESER) begin
                parity_reg     <= !parity_reg;
                phase_step_reg <= parity_reg;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_reg <= 1'b0;
        end else begin
            seen_reg <= link.comma_logic_enable
                     && ((plus_hit && link.plus_detect_report)
                     || (minus_hit && link.minus_detect_report));
        end
    end

    // data lags the flags by the pipe; bypass trades alignment for one-cycle latency
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < rca_pkg::PIPE_N; i++) begin
                pipe_reg[i] <= '0;
            end
            word_reg <= '0;
        end else begin
            pipe_reg[0] <= aligned_word;
            for (int i = 1; i < rca_pkg::PIPE_N; i++) begin
                pipe_reg[i] <= pipe_reg[i-1];
            end
            word_reg <= link.comma_logic_enable ? pipe_reg[rca_pkg::PIPE_N-1]
                                                : raw_word_in;
        end
    end

    assign link.parallel_rx_word     = word_reg;
    assign link.byte_aligned_flag    = aligned_reg;
    assign link.realign_pulse        = realign_reg;
    assign link.comma_seen           = seen_reg;
    assign link.recovered_phase_step = phase_step_reg;
endmodule : rca_aligner_dev

/* src/rca_link_ctrl.sv */
// user-side controller that configures the aligner and issues bit slips
`timescale 1ns/10ps
module rca_link_ctrl (
    input  wire logic        sys_clk,  // parallel clock
    input  wire logic        rst_n,    // async reset
    input  wire logic [7:0]  reg_addr, // byte address
    input  wire logic [31:0] reg_wdata, // write data
    input  wire logic        reg_wr,   // write strobe
    input  wire logic        reg_rd,   // read strobe
    output logic      [31:0] reg_rdata, // read data, cycle after strobe
    rca_link_if.host         link      // aligner configuration and status
);
    localparam logic [5:0] SLIP_LOAD = rca_pkg::SLIP_LOW_MIN + rca_pkg::SLIP_HIGH_CYC;

    logic [rca_pkg::CTRL_W-1:0] ctrl_reg;
    logic [9:0]                 plus_reg;
    logic [9:0]                 minus_reg;
    logic [9:0]                 mask_reg;
    logic                       realign_st_reg;
    logic                       comma_st_reg;
    logic [5:0]                 slip_cnt_reg;
    logic [rca_pkg::WORD_W-1:0] word_reg;
    logic [31:0]                rdata_reg;
    logic [1:0]                 gran_req;
    logic                       manual;
    logic [31:0]                status_w;

    assign gran_req = ctrl_reg[rca_pkg::CB_GRAN_LO +: 2];
    assign manual   = ctrl_reg[rca_pkg::CB_SLIP_LO +: 2] != 2'h0;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg  <= rca_pkg::CTRL_RST;
            plus_reg  <= rca_pkg::PLUS_RST;
            minus_reg <= rca_pkg::MINUS_RST;
            mask_reg  <= rca_pkg::MASK_RST;
        end else if (reg_wr) begin
            if (reg_addr == rca_pkg::OFS_CTRL) begin
                ctrl_reg <= reg_wdata[rca_pkg::CTRL_W-1:0];
            end
            if (reg_addr == rca_pkg::OFS_PATTERN) begin
                plus_reg  <= reg_wdata[9:0];
                minus_reg <= reg_wdata[rca_pkg::PB_MINUS_LO +: 10];
            end
            if (reg_addr == rca_pkg::OFS_MASK) begin
                mask_reg <= reg_wdata[9:0];
            end
        end
    end

    // sticky status: a new event in the clearing cycle survives
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            realign_st_reg <= 1'b0;
            comma_st_reg   <= 1'b0;
        end else begin
            if (link.realign_pulse) begin
                realign_st_reg <= 1'b1;
            end else if (reg_wr && reg_addr == rca_pkg::OFS_STATUS
                         && reg_wdata[rca_pkg::SB_REALIGN]) begin
                realign_st_reg <= 1'b0;
            end
            if (link.comma_seen) begin
                comma_st_reg <= 1'b1;
            end else if (reg_wr && reg_addr == rca_pkg::OFS_STATUS
                         && reg_wdata[rca_pkg::SB_COMMA]) begin
                comma_st_reg <= 1'b0;
            end
        end
    end

    // two cycles high then 33 low; orders during that time are dropped
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            slip_cnt_reg <= 6'h00;
        end else if (slip_cnt_reg != 6'h00) begin
            slip_cnt_reg <= slip_cnt_reg - 6'h01;
        end else if (reg_wr && reg_addr == rca_pkg::OFS_SLIP && reg_wdata[0] && manual) begin
            slip_cnt_reg <= SLIP_LOAD;
        end
    end

    // the word may move between two halves being read; read low then high
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            word_reg <= '0;
        end else begin
            word_reg <= link.parallel_rx_word;
        end
    end

    assign status_w = {28'h0000000, slip_cnt_reg != 6'h00, comma_st_reg,
                       realign_st_reg, link.byte_aligned_flag};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                rca_pkg::OFS_CTRL:    rdata_reg <= {20'h00000, ctrl_reg};
                rca_pkg::OFS_PATTERN: rdata_reg <= {6'h00, minus_reg, 6'h00, plus_reg};
                rca_pkg::OFS_MASK:    rdata_reg <= {22'h000000, mask_reg};
                rca_pkg::OFS_STATUS:  rdata_reg <= status_w;
                rca_pkg::OFS_WORD_LO: rdata_reg <= word_reg[31:0];
                rca_pkg::OFS_WORD_HI: rdata_reg <= {24'h000000, word_reg[39:32]};
                default:              rdata_reg <= 32'h00000000;
            endcase
        end else begin
            rdata_reg <= 32'h00000000;
        end
    end

    assign reg_rdata = rdata_reg;

    assign link.bit_slip_request    = slip_cnt_reg > rca_pkg::SLIP_LOW_MIN;
    assign link.comma_logic_enable  = ctrl_reg[rca_pkg::CB_LOGIC_EN] || manual;
    assign link.plus_align_enable   = ctrl_reg[rca_pkg::CB_PLUS_AL] && !manual;
    assign link.minus_align_enable  = (ctrl_reg[rca_pkg::CB_PAIRED]
                                      ? ctrl_reg[rca_pkg::CB_PLUS_AL]
                                      : ctrl_reg[rca_pkg::CB_MINUS_AL]) && !manual;
    assign link.paired_mode         = ctrl_reg[rca_pkg::CB_PAIRED];
    assign link.plus_detect_report  = ctrl_reg[rca_pkg::CB_PLUS_REP];
    assign link.minus_detect_report = ctrl_reg[rca_pkg::CB_PAIRED]
                                      ? ctrl_reg[rca_pkg::CB_PLUS_REP]
                                      : ctrl_reg[rca_pkg::CB_MINUS_REP];
    assign link.gran_code = ctrl_reg[rca_pkg::CB_ANY_POS] ? rca_pkg::GRAN_1
                          : (gran_req == rca_pkg::GRAN_4 && !ctrl_reg[rca_pkg::CB_INT_WIDTH])
                          ? rca_pkg::GRAN_2 : gran_req;
    assign link.internal_width      = ctrl_reg[rca_pkg::CB_INT_WIDTH];
    assign link.slip_mode_select    = rca_pkg::rca_slip_t'(ctrl_reg[rca_pkg::CB_SLIP_LO +: 2]);
    assign link.plus_comma_pattern  = plus_reg;
    assign link.minus_comma_pattern = minus_reg;
    assign link.comma_mask          = mask_reg;
endmodule : rca_link_ctrl

/* verification/rca_link_chk.sv */
// concurrent checks on the aligner link
`timescale 1ns/10ps
module rca_link_chk (
    input wire logic               sys_clk,             // clock
    input wire logic               rst_n,               // reset
    input wire logic               comma_logic_enable,  // aligner used
    input wire logic               plus_align_enable,   // plus aligns
    input wire logic               minus_align_enable,  // minus aligns
    input wire logic               bit_slip_request,    // slip level
    input wire rca_pkg::rca_slip_t slip_mode_select,    // slip mode
    input wire logic               byte_aligned_flag,   // aligned
    input wire logic               realign_pulse,       // realigned
    input wire logic               recovered_phase_step, // clock step
    input wire logic               paired_mode          // paired commas
);
    logic [5:0] low_cnt;
    // saturates, so a slip right after reset counts as legal
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) low_cnt <= 6'h3f;
        else if (bit_slip_request) low_cnt <= 6'h00;
        else if (low_cnt != 6'h3f) low_cnt <= low_cnt + 6'h01;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    AST_SLIP_WIDTH: assert property (
        $rose(bit_slip_request) |=> bit_slip_request ##1 !bit_slip_request)
        else $error("slip width");
    AST_SLIP_GAP: assert property ($rose(bit_slip_request) |-> low_cnt > 6'h20)
        else $error("slip gap short");
    AST_BYPASS: assert property (!comma_logic_enable |=> !byte_aligned_flag)
        else $error("aligned while bypassed");
    AST_PULSE_ONE: assert property (realign_pulse |=> !realign_pulse)
        else $error("realign pulse long");
    AST_PULSE_CLR: assert property (realign_pulse |-> !byte_aligned_flag)
        else $error("aligned during realign");
    AST_SLIP_WINS: assert property (bit_slip_request |=> !realign_pulse)
        else $error("realign during slip");
    AST_SLIP_CFG: assert property (slip_mode_select != rca_pkg::RCA_SLIP_OFF |->
        comma_logic_enable && !plus_align_enable && !minus_align_enable)
        else $error("slip config");
    AST_PAIR_EQ: assert property (paired_mode |-> plus_align_enable == minus_align_enable)
        else $error("paired enables differ");
    AST_PHASE: assert property (recovered_phase_step |->
        $past(bit_slip_request) && slip_mode_select[1] ##1 !recovered_phase_step)
        else $error("phase step");
    COV_REALIGN: cover property (realign_pulse);
    COV_ALIGNED: cover property ($rose(byte_aligned_flag));
    COV_PHASE: cover property (recovered_phase_step);
endmodule : rca_link_chk

/* verification/rx_comma_byte_aligner_tb.sv */
// self-checking bench: controller configures the aligner over the link
`timescale 1ns/10ps
module rx_comma_byte_aligner_tb;
    logic        sys_clk, rst_n, reg_wr, reg_rd, found;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [39:0] raw_word_in, e;
    int          error_cnt, num_checks, phase_cnt, s, q;
    rca_link_if link ();
    rca_aligner_dev rca_aligner_dev_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .raw_word_in(raw_word_in), .link(link));
    rca_link_ctrl rca_link_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .link(link));
    rca_link_chk rca_link_chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .comma_logic_enable(link.comma_logic_enable), .plus_align_enable(link.plus_align_enable),
        .minus_align_enable(link.minus_align_enable), .bit_slip_request(link.bit_slip_request),
        .slip_mode_select(link.slip_mode_select), .byte_aligned_flag(link.byte_aligned_flag),
        .realign_pulse(link.realign_pulse), .recovered_phase_step(link.recovered_phase_step),
        .paired_mode(link.paired_mode));
    initial forever #2.5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) phase_cnt += int'(link.recovered_phase_step === 1'h1);
    task automatic chk(input string n, input logic [39:0] x, input logic [39:0] y);
        num_checks++;
        if (y !== x) begin
            $display("unexpected %s expected %h seen %h", n, x, y);
            error_cnt++;
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_wr    <= w;
        reg_rd    <= !w;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_wr    <= 1'h0;
        reg_rd    <= 1'h0;
        #1 d = reg_rdata;
    endtask : bus
    // zero filler matches neither pattern, so only the sent comma can land;
    // only don't-care bits 2:1 vary, other low values meet the filler as a false minus comma
    task automatic send(input int p, input logic pair);
        @(posedge sys_clk);
        raw_word_in <= 40'({rca_pkg::MINUS_RST & {10{pair}},
                            rca_pkg::PLUS_RST ^ 10'($urandom_range(2, 0) << 1)}) << p;
        @(posedge sys_clk);
        raw_word_in <= '0;
        found = 1'h0;
        repeat (10) begin
            @(posedge sys_clk);
            #1;
            for (int k = 0; k < 40; k += s)
                found |= ((link.parallel_rx_word[k+:10] ^ rca_pkg::PLUS_RST) & 10'h3f0) == '0;
        end
    endtask : send
    // the controller drops orders while busy, so wait out its whole window
    task automatic slip;
        bus(1'h1, rca_pkg::OFS_SLIP, 32'h1);
        repeat (40) @(posedge sys_clk);
        #1;
    endtask : slip
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        {sys_clk, rst_n, reg_wr, reg_rd, found, reg_addr, reg_wdata, raw_word_in} = '0;
        void'($urandom(32'h0f25718b));
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'h1;
        bus(1'h0, rca_pkg::OFS_CTRL, 32'h0);
        chk("ctrl reset", 40'h177, {8'h00, d});
        bus(1'h0, 8'h1c, 32'h0);
        chk("unmapped read", 40'h0, {8'h00, d});
        $display("test registers done");
        bus(1'h1, rca_pkg::OFS_MASK, 32'h3f0);
        for (int g = 0; g < 4; g++) begin
            s = 10 << (g % 3);
            bus(1'h1, rca_pkg::OFS_CTRL, 32'h137 | 32'(g % 3 << 6) | 32'(g / 3 << 3));
            repeat (3) begin
                q = $urandom_range(30 - 10 * (g / 3), 0);
                bus(1'h1, rca_pkg::OFS_STATUS, 32'h6);
                send(q, g == 3);
                send(q, g == 3);
                bus(1'h0, rca_pkg::OFS_STATUS, 32'h0);
                chk("status", 40'h5, {8'h00, d} & 40'h5);
                chk("comma lane", 40'h1, {39'h0, found});
            end
        end
        $display("test alignment done");
        bus(1'h1, rca_pkg::OFS_CTRL, 32'h0);
        repeat (4) begin
            @(posedge sys_clk);
            raw_word_in <= 40'({$urandom(), $urandom()});
            @(posedge sys_clk);
            #1 chk("bypass word", raw_word_in, link.parallel_rx_word);
        end
        $display("test bypass done");
        rst_n <= 1'h0;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'h1;
        raw_word_in <= 40'h1;
        bus(1'h1, rca_pkg::OFS_CTRL, 32'h201);
        for (int i = 1; i <= 11; i++) begin
            slip();
            e = (i % 10 == 0) ? 40'h1 : 40'h1 << (40 - i % 10);
            chk("slip word", e, link.parallel_rx_word);
        end
        bus(1'h1, rca_pkg::OFS_CTRL, 32'h601);
        phase_cnt = 0;
        repeat (2) slip();
        chk("deser word", 40'h1 << 31, link.parallel_rx_word);
        chk("phase steps", 40'h1, 40'(phase_cnt));
        $display("test slip done");
        tally_and_finish();
    end
endmodule : rx_comma_byte_aligner_tb
